/* File: include/scd_pkg.sv */
package scd_pkg;

   // ***************************************************************
   // register map (byte addresses, one aligned word each)
   // ***************************************************************
   localparam logic [11:0] CLOCK_CONTROL_OFFS = 12'h000;
   localparam logic [11:0] CLOCK_STATUS_OFFS  = 12'h004;
   localparam logic [11:0] CYCLE_COUNT_OFFS   = 12'h008;

   // ***************************************************************
   // clock_control fields
   // ***************************************************************
   localparam int CTRL_W                 = 4;
   localparam int SOURCE_SELECT_BIT      = 0;
   localparam int MAIN_OSC_DISABLE_BIT   = 1;
   localparam int DIVIDE_SEL_LOW_BIT     = 2;
   localparam int DIVIDE_SEL_HIGH_BIT    = 3;
   localparam logic [3:0] CLOCK_CONTROL_RST = 4'hf;

   localparam logic SRC_MAIN_OSC = 1'b0;
   localparam logic SRC_RING_OSC = 1'b1;

   // ***************************************************************
   // clock_status fields
   // ***************************************************************
   localparam int STAT_ACTIVE_CFG_LSB = 0;
   localparam int STAT_INSTR_PHASE_LSB = 4;
   localparam int STAT_PENDING_BIT    = 6;

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam int INSTR_DIVIDE     = 3;
   localparam int MAX_SYS_DIVIDE   = 8;
   localparam int SYS_CNT_W        = 3;
   localparam int INSTR_CNT_W      = 2;

   typedef enum logic [1:0] {
      SCD_DIV1 = 2'b00,
      SCD_DIV2 = 2'b01,
      SCD_DIV4 = 2'b10,
      SCD_DIV8 = 2'b11
   } scd_divide_e;

endpackage

/* File: logic/scd_system_clock.sv */
// Summary of operation
// R01: source bit 0 picks main or ring
// R02: bits 3:2 divide by 1, 2, 4, 8
// R03: bit 1 zero for main, ignored ring
// R04: instruction clock is system clock over three
// R05: one instruction period is one machine cycle
// R06: reset selects ring oscillator divided by eight
// R07: software keeps ring oscillator running when chosen
// R08: all external sources form one main clock
// R09: start main oscillation before selecting it
// R10: start oscillation and switch in separate writes
// R11: dividers reset in phase, switching without glitches
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
module scd_system_clock #(
   parameter int CYCLE_CNT_W = 16
) (
   // clock and reset
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // apb slave
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic                        pready,
   output logic [31:0]                 prdata,
   output logic                        pslverr,
   // oscillator ticks, one pulse per source period
   input  wire logic                   main_osc_tick,
   input  wire logic                   ring_osc_tick,
   // oscillator control
   output logic                        main_osc_enable,
   // derived clock enables and machine cycle count
   output logic                        system_clock,
   output logic                        instruction_clock,
   output logic                        machine_cycle,
   output logic [CYCLE_CNT_W-1:0]      machine_cycle_count
);

   // ***************************************************************
   // elaboration checks
   // ***************************************************************
   if (CYCLE_CNT_W < 1 || CYCLE_CNT_W > 24) begin : g_bad_width
      $error("CYCLE_CNT_W must lie in 1..24");
   end
   // the shared constants must fit the fixed divide table, the counters
   // and the register field; refuse a set that the logic cannot serve
   if (scd_pkg::CTRL_W != 4) begin : g_bad_ctrl_w
      $error("clock_control must be four bits wide");
   end
   if (scd_pkg::MAX_SYS_DIVIDE != 8) begin : g_bad_max_divide
      $error("divide table covers ratios up to eight only");
   end
   if ((1 << scd_pkg::SYS_CNT_W) < scd_pkg::MAX_SYS_DIVIDE) begin : g_bad_sys_cnt_w
      $error("system divider counter too narrow for the largest ratio");
   end
   if ((1 << scd_pkg::INSTR_CNT_W) < scd_pkg::INSTR_DIVIDE) begin : g_bad_instr_cnt_w
      $error("instruction divider counter too narrow");
   end

   // ***************************************************************
   // decode helpers
   // ***************************************************************
   // terminal count of the system divider for a divide selection
   function automatic logic [2:0] div_last(input logic [1:0] sel);
      logic [2:0] last;
      last = 3'h0;
      case (scd_pkg::scd_divide_e'(sel))
         scd_pkg::SCD_DIV1: last = 3'h0;
         scd_pkg::SCD_DIV2: last = 3'h1;
         scd_pkg::SCD_DIV4: last = 3'h3;
         scd_pkg::SCD_DIV8: last = 3'h7;
         default:           last = 3'h0;
      endcase
      return last;
   endfunction

   // divide selection field of a clock_control value
   function automatic logic [1:0] div_field(input logic [3:0] ctrl);
      return {ctrl[scd_pkg::DIVIDE_SEL_HIGH_BIT], ctrl[scd_pkg::DIVIDE_SEL_LOW_BIT]};
   endfunction

   // last phase of the divide-by-three counter
   function automatic logic instr_at_last(input logic [scd_pkg::INSTR_CNT_W-1:0] cnt);
      return cnt == 2'(scd_pkg::INSTR_DIVIDE - 1);
   endfunction

   // ***************************************************************
   // declarations
   // ***************************************************************
   logic [scd_pkg::CTRL_W-1:0]      clock_control_r;
   logic [scd_pkg::CTRL_W-1:0]      active_cfg_r;
   logic [scd_pkg::SYS_CNT_W-1:0]   sys_cnt_r;
   logic [scd_pkg::INSTR_CNT_W-1:0] instr_cnt_r;
   logic                            pready_r;
   logic [31:0]                     prdata_r;
   logic                            pslverr_r;
   logic                            sys_tick_r;
   logic                            instr_tick_r;
   logic                            mcyc_tick_r;
   logic [CYCLE_CNT_W-1:0]          mcyc_cnt_r;
   logic                            main_osc_enable_r;

   logic                            setup_phase;
   logic                            write_now;
   logic                            src_tick;
   logic                            sys_wrap;
   logic                            cfg_pending;
   logic [2:0]                      active_last;
   logic [31:0]                     rd_word;
   logic                            addr_ok;
   logic                            instr_wrap;
   logic                            src_stopped;

   assign setup_phase = psel && !penable;
   assign write_now   = psel && penable && pready_r && pwrite && !pslverr_r;

   // ***************************************************************
   // apb slave: one access cycle, zero wait states
   // ***************************************************************
   always_comb begin
      rd_word = 32'h0000_0000;
      addr_ok = 1'b1;
      case (paddr)
         scd_pkg::CLOCK_CONTROL_OFFS: begin
            rd_word[scd_pkg::CTRL_W-1:0] = clock_control_r;
         end
         scd_pkg::CLOCK_STATUS_OFFS: begin
            rd_word[scd_pkg::STAT_ACTIVE_CFG_LSB +: scd_pkg::CTRL_W] = active_cfg_r;
            rd_word[scd_pkg::STAT_INSTR_PHASE_LSB +: scd_pkg::INSTR_CNT_W] = instr_cnt_r;
            rd_word[scd_pkg::STAT_PENDING_BIT] = cfg_pending;
         end
         scd_pkg::CYCLE_COUNT_OFFS: begin
            rd_word[CYCLE_CNT_W-1:0] = mcyc_cnt_r;
         end
         default: begin
            addr_ok = 1'b0;
         end
      endcase
   end

   // every setup is answered in the very next cycle: no wait states
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pready_r <= 1'b0;
      end else begin
         pready_r <= setup_phase;
      end
   end

   // captured at setup so it stands through the access cycle; writes
   // answer zero so stale read data never shows on the bus
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_word;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pslverr_r <= 1'b0;
      end else begin
         pslverr_r <= setup_phase && !addr_ok;
      end
   end

   // ***************************************************************
   // clock control register
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         clock_control_r <= scd_pkg::CLOCK_CONTROL_RST;             // [R06]
      end else if (write_now && paddr == scd_pkg::CLOCK_CONTROL_OFFS) begin
         clock_control_r <= pwdata[scd_pkg::CTRL_W-1:0];
      end
   end

   // ***************************************************************
   // main oscillator control
   // ***************************************************************
   // oscillation start follows the disable bit; the clock source does not
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         main_osc_enable_r <= ~scd_pkg::CLOCK_CONTROL_RST[scd_pkg::MAIN_OSC_DISABLE_BIT];
      end else begin
         main_osc_enable_r <= !clock_control_r[scd_pkg::MAIN_OSC_DISABLE_BIT]; // [R03] [R09]
      end
   end

   // ***************************************************************
   // source selection and system divider
   // ***************************************************************
   // a new setting is adopted only at a period boundary or while the main source is stopped, so no
   // shortened or stretched system clock period can appear
   assign cfg_pending = (active_cfg_r != clock_control_r);
   assign active_last = div_last(div_field(active_cfg_r));

   always_comb begin
      // the main clock tick is whatever the external circuit delivers
      if (active_cfg_r[scd_pkg::SOURCE_SELECT_BIT] == scd_pkg::SRC_RING_OSC) begin
         src_tick = ring_osc_tick;                                  // [R01]
      end else begin
         // a stopped main oscillator simply yields no ticks
         src_tick = main_osc_tick && main_osc_enable_r;             // [R01] [R08] [R03]
      end
   end

   assign sys_wrap = src_tick && (sys_cnt_r == active_last);

   // ***************************************************************
   // adoption of a new setting
   // ***************************************************************
   // a main source switched off mid-period would freeze the divider away
   // from zero and block every later switch; no pulse can be cut short
   // while it is stopped, so the setting may change at once then
   assign src_stopped = (active_cfg_r[scd_pkg::SOURCE_SELECT_BIT] == scd_pkg::SRC_MAIN_OSC)
                        && !main_osc_enable_r;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active_cfg_r <= scd_pkg::CLOCK_CONTROL_RST;                // [R06]
      end else if ((sys_cnt_r == 3'h0 || src_stopped) && !src_tick) begin
         active_cfg_r <= clock_control_r;                           // [R11]
      end
   end

   // ***************************************************************
   // system divider
   // ***************************************************************
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_cnt_r <= 3'h0;                                         // [R11]
      end else if (sys_wrap) begin
         sys_cnt_r <= 3'h0;                                         // [R02]
      end else if (src_stopped) begin
         sys_cnt_r <= 3'h0;                                         // [R11]
      end else if (src_tick) begin
         sys_cnt_r <= sys_cnt_r + 3'h1;                             // [R02]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sys_tick_r <= 1'b0;
      end else begin
         sys_tick_r <= sys_wrap;                                    // [R02]
      end
   end

   // ***************************************************************
   // instruction clock and machine cycle
   // ***************************************************************
   assign instr_wrap = sys_wrap && instr_at_last(instr_cnt_r);

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_cnt_r <= 2'h0;                                       // [R11]
      end else if (instr_wrap) begin
         instr_cnt_r <= 2'h0;                                       // [R04]
      end else if (sys_wrap) begin
         instr_cnt_r <= instr_cnt_r + 2'h1;                         // [R04]
      end
   end

   // registered like the system pulse, so the enables land in one cycle
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         instr_tick_r <= 1'b0;
      end else begin
         instr_tick_r <= instr_wrap;                                // [R04]
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mcyc_tick_r <= 1'b0;
      end else begin
         mcyc_tick_r <= instr_wrap;                                 // [R05]
      end
   end

   // free-running, wraps silently; software compares differences
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mcyc_cnt_r <= '0;
      end else if (mcyc_tick_r) begin
         mcyc_cnt_r <= mcyc_cnt_r + CYCLE_CNT_W'(1);                // [R05]
      end
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   assign pready              = pready_r;
   assign prdata              = prdata_r;
   assign pslverr             = pslverr_r;
   assign main_osc_enable     = main_osc_enable_r;
   assign system_clock        = sys_tick_r;
   assign instruction_clock   = instr_tick_r;
   assign machine_cycle       = mcyc_tick_r;
   assign machine_cycle_count = mcyc_cnt_r;

endmodule // scd_system_clock

/* File: sim/scd_system_clock_props.sv */
// ***************************************************
// port checker for the system clock block
// ***************************************************
module scd_system_clock_props #(
   parameter int CYCLE_CNT_W = 16
) (
   // apb side
   input wire logic                   clk,
   input wire logic                   arst_n,
   input wire logic                   psel,
   input wire logic                   penable,
   input wire logic                   pwrite,
   input wire logic [11:0]            paddr,
   input wire logic [31:0]            pwdata,
   input wire logic                   pready,
   input wire logic [31:0]            prdata,
   input wire logic                   pslverr,
   // clock side
   input wire logic                   main_osc_tick,
   input wire logic                   ring_osc_tick,
   input wire logic                   main_osc_enable,
   input wire logic                   system_clock,
   input wire logic                   instruction_clock,
   input wire logic                   machine_cycle,
   input wire logic [CYCLE_CNT_W-1:0] machine_cycle_count
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   logic [1:0] sys_cnt_r;
   // own phase of system pulses, reset aligned like the design
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) sys_cnt_r <= 2'h0;
      else if (system_clock) sys_cnt_r <= (sys_cnt_r == 2'h2) ? 2'h0 : sys_cnt_r + 2'h1;
   end
   sequence s_setup; psel && !penable; endsequence
   sequence s_ctrl_wr;
      psel && penable && pready && pwrite && !pslverr && paddr == scd_pkg::CLOCK_CONTROL_OFFS;
   endsequence
   property p_apb_answer; s_setup |=> pready; endproperty
   a_apb_answer: assert property (p_apb_answer) else $error("no answer after setup");
   property p_ready_pulse; pready |=> !pready; endproperty
   a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
   property p_unmapped;
      (psel && !penable && paddr > scd_pkg::CYCLE_COUNT_OFFS) |=> pslverr && prdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
   property p_osc_enable;
      s_ctrl_wr |-> ##2 main_osc_enable == !$past(pwdata[scd_pkg::MAIN_OSC_DISABLE_BIT], 2);
   endproperty
   a_osc_enable: assert property (p_osc_enable) else $error("oscillator enable wrong");
   property p_tick_cause;
      system_clock |-> $past(ring_osc_tick || (main_osc_tick && main_osc_enable));
   endproperty
   a_tick_cause: assert property (p_tick_cause) else $error("pulse without tick");
   property p_instr_div3; instruction_clock == (system_clock && sys_cnt_r == 2'h2); endproperty
   a_instr_div3: assert property (p_instr_div3) else $error("not every third");
   property p_machine_same; machine_cycle == instruction_clock; endproperty
   a_machine_same: assert property (p_machine_same) else $error("machine cycle off");
   property p_count_step;
      machine_cycle |=> machine_cycle_count == CYCLE_CNT_W'($past(machine_cycle_count) + 1'b1);
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not step");
endmodule // scd_system_clock_props

bind scd_system_clock scd_system_clock_props #(.CYCLE_CNT_W(CYCLE_CNT_W)) u_props (
   .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
   .main_osc_tick, .ring_osc_tick, .main_osc_enable, .system_clock, .instruction_clock,
   .machine_cycle, .machine_cycle_count);

/* File: sim/system_clock_select_divider_test.sv */
// ***************************************************
// bench for the system clock block
// ***************************************************
module system_clock_select_divider_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic        main_osc_tick = 1'b0, ring_osc_tick = 1'b0, rerr, pready, pslverr;
   logic        main_osc_enable, system_clock, instruction_clock, machine_cycle;
   logic [15:0] machine_cycle_count;
   logic [2:0]  ph = 3'h0;
   int          err_total = 0, checks_done = 0;
   scd_system_clock #(.CYCLE_CNT_W(16)) uut (
      .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr,
      .main_osc_tick, .ring_osc_tick, .main_osc_enable, .system_clock, .instruction_clock,
      .machine_cycle, .machine_cycle_count);
   initial forever #20 clk = ~clk;
   // ring ticks every 2nd cycle, main every 3rd: gaps let a switch land
   always @(posedge clk) begin
      ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
      ring_osc_tick <= ph[0];
      main_osc_tick <= (ph == 3'h0 || ph == 3'h3);
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic hang();
      err_total++;
      $display("Error at %0t: wait ran out", $time);
      report_and_stop();
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // cycles between the next two system pulses
   task automatic measure(output int n);
      repeat (2) begin
         n = 0;
         do begin
            @(posedge clk);
            #1;
            n++;
         end while (system_clock !== 1'b1 && n < 100);
      end
      if (system_clock !== 1'b1) hang();
   endtask
   task automatic test_reset();
      int n;
      arst_n <= 1'b0;
      repeat (6) @(posedge clk);
      arst_n <= 1'b1;
      apb(1'b0, scd_pkg::CLOCK_CONTROL_OFFS, 32'h0000_0000);
      check(rdat, 32'h0000_000f);
      apb(1'b0, scd_pkg::CLOCK_STATUS_OFFS, 32'h0000_0000);
      check(rdat, 32'h0000_000f);
      apb(1'b0, scd_pkg::CYCLE_COUNT_OFFS, 32'h0000_0000);
      check(rdat, 32'h0000_0000);
      check(main_osc_enable, 1'b0);
      measure(n);
      check(n, 16);
      $display("test_reset done");
   endtask
   task automatic test_modes();
      logic [3:0] cfg;
      int         n;
      // ring settings first, so main starts before it is chosen
      for (int i = 0; i < 12; i++) begin
         cfg = (i < 8) ? 4'(15 - 2 * i) : 4'(4 * (i - 8));
         apb(1'b1, scd_pkg::CLOCK_CONTROL_OFFS, {28'h000_0000, cfg});
         apb(1'b0, scd_pkg::CLOCK_CONTROL_OFFS, 32'h0000_0000);
         check(rdat, {28'h000_0000, cfg});
         check(main_osc_enable, !cfg[1]);
         measure(n);
         measure(n);
         check(n, (32'h1 << cfg[3:2]) * (cfg[0] ? 2 : 3));
         apb(1'b0, scd_pkg::CLOCK_STATUS_OFFS, 32'h0000_0000);
         check(rdat & 32'h0000_004f, {28'h000_0000, cfg});
      end
      apb(1'b1, scd_pkg::CLOCK_CONTROL_OFFS, 32'h0000_0002);
      repeat (60) @(posedge clk);
      n = 0;
      repeat (40) begin
         @(posedge clk);
         #1;
         if (system_clock !== 1'b0) n++;
      end
      check(n, 0);
      $display("test_modes done");
   endtask
   task automatic test_cycles();
      logic [15:0] first;
      int          n, m;
      apb(1'b1, scd_pkg::CLOCK_CONTROL_OFFS, 32'h0000_0001);
      measure(n);
      first = machine_cycle_count + 16'(machine_cycle);
      n = 0;
      m = 0;
      repeat (60) begin
         @(posedge clk);
         #1;
         if (instruction_clock === 1'b1) n++;
         if (machine_cycle === 1'b1) m++;
      end
      check(n, 10);
      check(m, 10);
      check({16'h0000, 16'(machine_cycle_count + 16'(machine_cycle) - first)}, m);
      $display("test_cycles done");
   endtask
   task automatic test_unmapped();
      apb(1'b1, 12'h00c, 32'h0000_0006);
      check(rerr, 1'b1);
      apb(1'b0, 12'h00c, 32'h0000_0000);
      check({rerr, rdat[30:0]}, 32'h8000_0000);
      apb(1'b0, scd_pkg::CLOCK_CONTROL_OFFS, 32'h0000_0000);
      check(rdat, 32'h0000_0001);
      $display("test_unmapped done");
   endtask
   initial begin
      test_reset();
      test_modes();
      test_cycles();
      test_unmapped();
      test_reset();
      report_and_stop();
   end
endmodule // system_clock_select_divider_test
